// >>> src/sram_ecc_pkg.sv
package sram_ecc_pkg;

    // ------------------------------------------------------------------
    // Word geometry
    // ------------------------------------------------------------------
    localparam int DATA_W  = 16;
    localparam int CHECK_W = 6;
    localparam int WORD_W  = DATA_W + CHECK_W;
    localparam int ADDR_W  = 11;

    // ------------------------------------------------------------------
    // Check bit masks
    // ------------------------------------------------------------------
    localparam logic [15:0] MASK_C0 = 16'h443F;
    localparam logic [15:0] MASK_C1 = 16'h13C7;
    localparam logic [15:0] MASK_C2 = 16'hE1D1;
    localparam logic [15:0] MASK_C3 = 16'hEE60;
    localparam logic [15:0] MASK_C4 = 16'h3E8A;
    localparam logic [15:0] MASK_C5 = 16'h993C;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_DATA  = 16'h0000;
    localparam logic [5:0]  RST_CHECK = 6'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CHECK_W-1:0] check;
        logic [DATA_W-1:0]  data;
    } ecc_word_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              single_err;
        logic              double_err;
    } read_result_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SYS_RD,
        ST_REPAIR,
        ST_DBG_RD
    } arb_state_e;

    // Computes all six check bits of one data word.
    function automatic logic [CHECK_W-1:0] calc_check(
        input logic [DATA_W-1:0] d
    );
        logic [CHECK_W-1:0] c;
        c[0] = ~(^(d & MASK_C0)); // see [RULE1]
        c[1] = ~(^(d & MASK_C1)); // see [RULE2]
        c[2] = ~(^(d & MASK_C2)); // see [RULE3]
        c[3] = ~(^(d & MASK_C3)); // see [RULE4]
        c[4] = ~(^(d & MASK_C4)); // see [RULE5]
        c[5] = ~(^(d & MASK_C5)); // see [RULE6]
        return c;
    endfunction

endpackage

// >>> src/ecc_decoder.sv
`timescale 1ns/10ps
module ecc_decoder
    import sram_ecc_pkg::*;
(
    // Raw stored word
    input  ecc_word_s    raw,
    // Decoded result
    output read_result_s result
);

    logic [CHECK_W-1:0] syndrome;
    logic [DATA_W-1:0]  fix;

    // Each data bit's signature is the set of masks that contain it; a
    // single flipped check bit gives a one-hot syndrome and needs no fix.
    always_comb begin
        syndrome = calc_check(raw.data) ^ raw.check;
        fix      = '0;
        for (int i = 0; i < DATA_W; i++) begin
            if (syndrome == {MASK_C5[i], MASK_C4[i], MASK_C3[i],
                             MASK_C2[i], MASK_C1[i], MASK_C0[i]}) begin
                fix[i] = 1'b1;
            end
        end
        result.data       = raw.data ^ fix; // see [RULE20]
        result.single_err = (fix != '0) || ($countones(syndrome) == 1);
        result.double_err = (syndrome != '0) && !result.single_err;
    end

endmodule // ecc_decoder

// >>> src/sram_ecc_codec_debug.sv
`timescale 1ns/10ps
// What this block does
// [RULE1] Check bit 0 is inverted parity of data masked with 443F.
// [RULE2] Check bit 1 is inverted parity of data masked with 13C7.
// [RULE3] Check bit 2 is inverted parity of data masked with E1D1.
// [RULE4] Check bit 3 is inverted parity of data masked with EE60.
// [RULE5] Check bit 4 is inverted parity of data masked with 3E8A.
// [RULE6] Check bit 5 is inverted parity of data masked with 993C.
// [RULE7] Six check bits are computed per 16-bit stored word.
// [RULE8] Debug path reads and writes raw data and check bits.
// [RULE9] Debug access starts only when no other access is pending.
// [RULE10] Debug access waits for memory initialization to finish.
// [RULE11] Disable-read-repair suppresses single-error write-back.
// [RULE12] Without repair, reads still return corrected data and flag.
// [RULE13] Debug write stores supplied check bits unaltered.
// [RULE14] Command bits cannot be set while a debug access is active.
// [RULE15] Software polls both command bits clear before a new access.
// [RULE16] Both command bits written together perform only the write.
// [RULE17] Command bits self-clear on completion; writing zero does nothing.
// [RULE18] Debug read loads raw data and raw check into registers.
// [RULE19] Command register writes only take effect in special mode.
// [RULE20] Normal reads correct single errors and report double errors.
module sram_ecc_codec_debug
    import sram_ecc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // System bus access, one word per request
    input  wire logic              sys_req,
    input  wire logic              sys_we,
    input  wire logic [AW-1:0]     sys_addr,
    input  wire logic [DATA_W-1:0] sys_wdata,
    output logic                   sys_ack,
    output logic [DATA_W-1:0]      sys_rdata,
    output logic                   single_error_flag,
    output logic                   double_error_flag,
    // Memory initialization engine
    input  wire logic              init_busy,
    input  wire logic              init_we,
    input  wire logic [AW-1:0]     init_addr,
    // Debug command register and its companions
    input  wire logic              special_mode,
    input  wire logic              cmd_wr,
    input  wire logic              cmd_wdata_repair_off,
    input  wire logic              cmd_wdata_write,
    input  wire logic              cmd_wdata_read,
    input  wire logic              ptr_wr,
    input  wire logic [AW-1:0]     ptr_wdata,
    input  wire logic              dd_wr,
    input  wire logic [DATA_W-1:0] dd_wdata,
    input  wire logic              de_wr,
    input  wire logic [CHECK_W-1:0] de_wdata,
    output logic                   disable_read_repair,
    output logic                   debug_write_cmd,
    output logic                   debug_read_cmd,
    output logic [AW-1:0]          debug_address_pointer,
    output logic [DATA_W-1:0]      debug_data_reg,
    output logic [CHECK_W-1:0]     debug_check_reg,
    // RAM array, one-cycle read latency
    output logic                   mem_en,
    output logic                   mem_we,
    output logic [AW-1:0]          mem_addr,
    output ecc_word_s              mem_wdata,
    input  wire ecc_word_s         mem_rdata
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    arb_state_e         state_q;
    logic [AW-1:0]      addr_q;
    logic               rep_off_q;
    logic               dwr_q;
    logic               drd_q;
    logic [AW-1:0]      ptr_q;
    logic [DATA_W-1:0]  dd_q;
    logic [CHECK_W-1:0] de_q;
    logic               dbg_done;
    read_result_s       dec;

    ecc_decoder u_dec (
        .raw    (mem_rdata),
        .result (dec)
    );

    // Debug starts only from idle, with no system request and no init.
    logic dbg_go;
    assign dbg_go = (state_q == ST_IDLE) && !sys_req && !init_busy
                    && (dwr_q || drd_q); // see [RULE9] see [RULE10]

    // ------------------------------------------------------------------
    // Debug command register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rep_off_q <= 1'b0;
            dwr_q     <= 1'b0;
            drd_q     <= 1'b0;
        end else begin
            if (cmd_wr && special_mode) begin // see [RULE19]
                rep_off_q <= cmd_wdata_repair_off;
            end
            if (dbg_done) begin
                dwr_q <= 1'b0; // see [RULE17]
                drd_q <= 1'b0;
            end else if (cmd_wr && special_mode && !dwr_q && !drd_q) begin
                // Zero writes are ignored; write wins over read.
                if (cmd_wdata_write) begin // see [RULE14] see [RULE16]
                    dwr_q <= 1'b1;
                end else if (cmd_wdata_read) begin // see [RULE17]
                    drd_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Debug pointer, data and check registers
    // ------------------------------------------------------------------
    // Writes from software are blocked while a command is active so a
    // debug read result cannot be mixed with a stale half.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= '0;
            dd_q  <= RST_DATA;
            de_q  <= RST_CHECK;
        end else begin
            if (state_q == ST_DBG_RD) begin
                dd_q <= mem_rdata.data;  // see [RULE18]
                de_q <= mem_rdata.check; // see [RULE8]
            end else if (!dwr_q && !drd_q) begin // see [RULE14]
                if (ptr_wr) begin
                    ptr_q <= ptr_wdata;
                end
                if (dd_wr) begin
                    dd_q <= dd_wdata;
                end
                if (de_wr) begin
                    de_q <= de_wdata;
                end
            end
        end
    end

    assign dbg_done = (dbg_go && dwr_q) || (state_q == ST_DBG_RD);

    // ------------------------------------------------------------------
    // Arbiter and memory port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            addr_q    <= '0;
            mem_en    <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
        end else begin
            mem_en <= 1'b0;
            mem_we <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (init_busy) begin
                        mem_en    <= init_we;
                        mem_we    <= init_we;
                        mem_addr  <= init_addr;
                        mem_wdata <= '{check: calc_check(RST_DATA),
                                       data:  RST_DATA};
                    end else if (sys_req && sys_we) begin
                        mem_en    <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= sys_addr;
                        mem_wdata <= '{check: calc_check(sys_wdata),
                                       data:  sys_wdata}; // see [RULE7]
                    end else if (sys_req) begin
                        mem_en   <= 1'b1;
                        mem_addr <= sys_addr;
                        addr_q   <= sys_addr;
                        state_q  <= ST_SYS_RD;
                    end else if (dbg_go && dwr_q) begin
                        mem_en    <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= ptr_q;
                        mem_wdata <= '{check: de_q,
                                       data:  dd_q}; // see [RULE13]
                    end else if (dbg_go) begin
                        mem_en   <= 1'b1;
                        mem_addr <= ptr_q;
                        state_q  <= ST_DBG_RD;
                    end
                end
                ST_SYS_RD: begin
                    if (dec.single_err && !rep_off_q) begin // see [RULE11]
                        mem_en    <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= addr_q;
                        mem_wdata <= '{check: calc_check(dec.data),
                                       data:  dec.data};
                        state_q   <= ST_REPAIR;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_REPAIR: state_q <= ST_IDLE;
                ST_DBG_RD: state_q <= ST_IDLE;
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // System answer
    // ------------------------------------------------------------------
    logic sys_wr_take;
    assign sys_wr_take = (state_q == ST_IDLE) && !init_busy
                         && sys_req && sys_we;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_ack           <= 1'b0;
            sys_rdata         <= '0;
            single_error_flag <= 1'b0;
            double_error_flag <= 1'b0;
        end else begin
            sys_ack           <= sys_wr_take || (state_q == ST_SYS_RD);
            single_error_flag <= 1'b0;
            double_error_flag <= 1'b0;
            if (state_q == ST_SYS_RD) begin
                sys_rdata         <= dec.data; // see [RULE12] see [RULE20]
                single_error_flag <= dec.single_err; // see [RULE12]
                double_error_flag <= dec.double_err; // see [RULE20]
            end
        end
    end

    assign disable_read_repair   = rep_off_q;
    assign debug_write_cmd       = dwr_q;
    assign debug_read_cmd        = drd_q;
    assign debug_address_pointer = ptr_q;
    assign debug_data_reg        = dd_q;
    assign debug_check_reg       = de_q;

endmodule // sram_ecc_codec_debug

// >>> verif/sram_ecc_checker_asserts.sv
`timescale 1ns/10ps
module sram_ecc_checker
    import sram_ecc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // System side
    input logic               clk, rst_n, sys_req, sys_we, sys_ack,
    input logic               single_error_flag, double_error_flag,
    input logic [AW-1:0]      sys_addr, mem_addr, debug_address_pointer,
    input logic [DATA_W-1:0]  sys_rdata, debug_data_reg,
    // Debug command side
    input logic               special_mode, cmd_wr, cmd_wdata_write,
    input logic               cmd_wdata_read, disable_read_repair,
    input logic               debug_write_cmd, debug_read_cmd,
    input logic [CHECK_W-1:0] debug_check_reg,
    // RAM side
    input logic               mem_en, mem_we,
    input ecc_word_s          mem_wdata, mem_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // The write may land on the clearing edge or one before it.
    logic dw_hit;
    assign dw_hit = mem_en && mem_we && mem_addr == debug_address_pointer
        && mem_wdata == {debug_check_reg, debug_data_reg};

    sequence s_sys_rd;
        mem_en && !mem_we && sys_req && !sys_we && mem_addr == sys_addr;
    endsequence
    sequence s_ack_late;
        !sys_ack ##1 sys_ack;
    endsequence
    sequence s_idle;
        cmd_wr && special_mode && !debug_write_cmd && !debug_read_cmd;
    endsequence

    property p_rd_ack;
        s_sys_rd |-> s_ack_late;
    endproperty
    property p_dbg_rd;
        $fell(debug_read_cmd) |-> $past(mem_en && !mem_we)
            && {debug_check_reg, debug_data_reg} == $past(mem_rdata);
    endproperty
    property p_dbg_wr;
        $fell(debug_write_cmd) |-> !$past(sys_req) && (dw_hit || $past(dw_hit));
    endproperty
    property p_lock;
        $rose(debug_write_cmd) || $rose(debug_read_cmd)
            |-> $past(cmd_wr && special_mode && !debug_write_cmd
                      && !debug_read_cmd);
    endproperty
    property p_both;
        s_idle ##0 (cmd_wdata_write && cmd_wdata_read)
            |=> debug_write_cmd && !debug_read_cmd;
    endproperty
    property p_flag;
        single_error_flag || double_error_flag
            |-> sys_ack && !(single_error_flag && double_error_flag);
    endproperty
    property p_norep;
        single_error_flag && disable_read_repair |-> !mem_en;
    endproperty
    property p_rep;
        single_error_flag && !disable_read_repair |-> mem_en && mem_we
            && mem_addr == sys_addr && mem_wdata.data == sys_rdata;
    endproperty

    a_rd_ack: assert property (p_rd_ack)
        else $error("read answer not two cycles after issue");
    a_dbg_rd: assert property (p_dbg_rd)
        else $error("debug read registers differ from raw word");
    a_dbg_wr: assert property (p_dbg_wr)
        else $error("debug write word or timing wrong");
    a_lock: assert property (p_lock)
        else $error("command bit set without a legal write");
    a_both: assert property (p_both)
        else $error("both command bits did not give a write");
    a_flag: assert property (p_flag)
        else $error("error flag outside a read answer");
    a_norep: assert property (p_norep)
        else $error("repair write while repair disabled");
    a_rep: assert property (p_rep)
        else $error("missing or wrong repair write");
endmodule // sram_ecc_checker

// >>> verif/sram_array_model.sv
`timescale 1ns/10ps
module sram_array_model
    import sram_ecc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input logic          clk, mem_en, mem_we,
    input logic [AW-1:0] mem_addr,
    input ecc_word_s     mem_wdata,
    output ecc_word_s    mem_rdata
);
    ecc_word_s cells [0:(1<<AW)-1];
    ecc_word_s junk_q;

    // The design samples read data at the edge that ends its read cycle,
    // so the port answers within that cycle; outside it the port shows a
    // toggling word so that stale use shows.
    initial junk_q = '0;
    assign mem_rdata = (mem_en && !mem_we) ? cells[mem_addr] : junk_q;
    always @(posedge clk) begin
        if (mem_en && mem_we)
            cells[mem_addr] <= mem_wdata;
        junk_q <= ~junk_q;
    end
endmodule // sram_array_model

// >>> verif/sram_ecc_codec_debug_tb_top.sv
`timescale 1ns/10ps
module sram_ecc_codec_debug_tb_top;
    import sram_ecc_pkg::*;
    logic clk = 0, rst_n = 0, sys_req = 0, sys_we = 0, init_busy = 0;
    logic init_we = 0, special_mode = 1, cmd_wr = 0, cmd_wdata_write = 0;
    logic cmd_wdata_read = 0, cmd_wdata_repair_off = 0, rr = 0;
    logic ptr_wr = 0, dd_wr = 0, de_wr = 0, sys_ack, mem_en, mem_we;
    logic single_error_flag, double_error_flag, disable_read_repair;
    logic debug_write_cmd, debug_read_cmd;
    logic [ADDR_W-1:0] sys_addr = '0, init_addr = '0, ptr_wdata = '0, a;
    logic [ADDR_W-1:0] debug_address_pointer, mem_addr;
    logic [DATA_W-1:0] sys_wdata = '0, dd_wdata = '0, d, sys_rdata;
    logic [DATA_W-1:0] debug_data_reg, dfl [4] = '{16'h0010, 16'h0010,
        16'h0101, 16'h0000};
    logic [CHECK_W-1:0] de_wdata = '0, debug_check_reg;
    logic [CHECK_W-1:0] cfl [4] = '{6'h00, 6'h00, 6'h00, 6'h04};
    ecc_word_s mem_wdata, mem_rdata;
    logic [31:0] r = 32'h1FDA;
    logic [DATA_W-1:0] exp_q [int];
    int a_q [$];
    int errors = 0, checks = 0, cyc = 0;

    sram_ecc_codec_debug sram_ecc_codec_debug_inst (.*);
    sram_array_model sram_array_model_inst (.*);

    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            errors++;
            final_report;
        end
    end

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [5:0] ecc6(logic [15:0] v);
        return ~{^(v & MASK_C5), ^(v & MASK_C4), ^(v & MASK_C3),
                 ^(v & MASK_C2), ^(v & MASK_C1), ^(v & MASK_C0)};
    endfunction
    task final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk_word(string n, logic [21:0] e, logic [21:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_flag(string n, logic e, logic g);
        chk_word(n, {21'h0, e}, {21'h0, g});
    endtask
    task sys(logic we, logic [10:0] ad, logic [15:0] wd);
        int n;
        @(posedge clk);
        sys_req <= 1;
        sys_we <= we;
        sys_addr <= ad;
        sys_wdata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (sys_ack !== 1'b1 && n < 20);
        sys_req <= 0;
        if (n >= 20) errors++;
    endtask
    task dbg_go(logic rd, logic [10:0] ad, logic [21:0] w);
        @(posedge clk);
        {ptr_wr, dd_wr, de_wr} <= 3'h7;
        {ptr_wdata, de_wdata, dd_wdata} <= {ad, w};
        @(posedge clk);
        {ptr_wr, dd_wr, de_wr} <= 3'h0;
        cmd_wr <= 1;
        cmd_wdata_write <= !rd;
        cmd_wdata_read <= 1;
        cmd_wdata_repair_off <= rr;
        @(posedge clk);
        cmd_wr <= 0;
    endtask
    task dbg_wait;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((debug_write_cmd | debug_read_cmd) !== 1'b0 && n < 40);
        if (n >= 40) errors++;
    endtask
    task dbg_rd(logic [10:0] ad, logic [21:0] e);
        dbg_go(1, ad, 22'h0);
        dbg_wait;
        chk_word("debug word", e, {debug_check_reg, debug_data_reg});
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            a = {r[7:0], i[2:0]};
            exp_q[a] = r[31:16];
            a_q.push_back(a);
            sys(1, a, r[31:16]);
        end
        foreach (a_q[i]) begin
            d = exp_q[a_q[i]];
            sys(0, a_q[i], 16'h0);
            chk_word("read data", d, sys_rdata);
            chk_flag("flags", 0, single_error_flag | double_error_flag);
            dbg_rd(a_q[i], {ecc6(d), d});
        end
        for (int k = 0; k < 4; k++) begin
            a = a_q[k];
            d = exp_q[a];
            rr = (k == 1);
            dbg_go(0, a, {ecc6(d) ^ cfl[k], d ^ dfl[k]});
            dbg_wait;
            sys(0, a, 16'h0);
            chk_flag("single flag", k != 2, single_error_flag);
            chk_flag("double flag", k == 2, double_error_flag);
            if (k != 2) chk_word("read data", d, sys_rdata);
            dbg_rd(a, (k == 1 || k == 2) ? {ecc6(d) ^ cfl[k], d ^ dfl[k]}
                                         : {ecc6(d), d});
        end
        rr = 0;
        @(posedge clk);
        special_mode <= 0;
        dbg_go(1, a_q[4], 22'h0);
        @(posedge clk);
        #1 chk_flag("read cmd", 0, debug_read_cmd);
        special_mode <= 1;
        init_busy <= 1;
        dbg_go(1, a_q[5], 22'h0);
        repeat (5) @(posedge clk);
        #1 chk_flag("read cmd held", 1, debug_read_cmd);
        dbg_go(0, a_q[6], 22'h3FFFFF);
        #1 chk_flag("write cmd", 0, debug_write_cmd);
        init_busy <= 0;
        dbg_wait;
        d = exp_q[a_q[5]];
        chk_word("debug word", {ecc6(d), d}, {debug_check_reg, debug_data_reg});
        final_report;
    end
endmodule // sram_ecc_codec_debug_tb_top

bind sram_ecc_codec_debug sram_ecc_checker #(.AW(AW)) sram_ecc_checker_inst (.*);
